/* File: logic/cpms_pkg.sv */
// Constants and types shared by the channel power and mute sequencer
package cpms_pkg;

  localparam int          NUM_CH        = 8;
  localparam int          VOL_W         = 8;
  localparam int          CNT_W         = 20;
  localparam int          SYNC_STAGES   = 3;

  // Register offsets on the control port
  localparam logic [7:0]  ADDR_CHAN_PWR = 8'h0D;
  localparam logic [7:0]  ADDR_GLB_PWR  = 8'h0E;
  localparam logic [7:0]  ADDR_ZC_CFG   = 8'h0F;
  localparam logic [7:0]  ADDR_STATUS   = 8'h1E;

  // Field positions
  localparam int          GLB_PDN_BIT   = 0;
  localparam int          ZC_MODE_BIT   = 0;
  localparam int          ZC_SEL_LSB    = 1;
  localparam int          ZC_SEL_W      = 3;
  localparam int          ZC_KEEP_BIT   = 4;
  localparam int          ZC_CFG_W      = 5;

  // Values after reset
  localparam logic [7:0]  RST_CHAN_PWR  = 8'h00;
  localparam logic [0:0]  RST_GLB_PDN   = 1'h1;
  localparam logic [4:0]  RST_ZC_CFG    = 5'h11;
  localparam logic [VOL_W-1:0] VOL_MUTE = 8'h00;

  // Timing: clock rate, time-out table and amplifier settling time
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned SETTLE_US     = 2000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_US * (CLK_HZ / 1000) + 999)
                                          / 1000;
  localparam int unsigned TO_MS [8]     = '{5, 10, 15, 20, 25, 30, 40, 50};

  typedef enum logic [1:0] {
    CH_OFF,
    CH_UP,
    CH_RUN,
    CH_DOWN
  } cpms_ch_state_t;

endpackage : cpms_pkg

/* File: logic/cpms_chan_if.sv */
// Signals between the sequencer top and one channel sequencer
`timescale 1ns/1ns
interface cpms_chan_if;
  logic                          pwr_en;
  logic [cpms_pkg::VOL_W-1:0]    vol_prog;
  logic                          zc;
  logic                          zc_mode;
  logic                          keep;
  logic [cpms_pkg::CNT_W-1:0]    timeout_cyc;
  logic [cpms_pkg::CNT_W-1:0]    settle_cyc;
  logic                          amp_on;
  logic [cpms_pkg::VOL_W-1:0]    vol_out;
  logic                          ready;

  modport ctrl (
    output pwr_en, vol_prog, zc, zc_mode, keep, timeout_cyc, settle_cyc,
    input  amp_on, vol_out, ready
  );
  modport chan (
    input  pwr_en, vol_prog, zc, zc_mode, keep, timeout_cyc, settle_cyc,
    output amp_on, vol_out, ready
  );
endinterface : cpms_chan_if

/* File: logic/cpms_channel.sv */
// One channel: amplifier power sequence and zero-crossing volume update
`timescale 1ns/1ns
module cpms_channel (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  cpms_chan_if.chan  ch
);
  import cpms_pkg::*;

  cpms_ch_state_t          state;
  logic [CNT_W-1:0]        settle_cnt;
  logic [CNT_W-1:0]        to_cnt;
  logic [VOL_W-1:0]        applied;
  logic [VOL_W-1:0]        pend_val;
  logic [VOL_W-1:0]        last_req;
  logic                    pend;
  logic                    req;
  logic [VOL_W-1:0]        req_val;
  logic                    settle_done;

  assign settle_done = (settle_cnt == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Volume requests raised by the power sequence or by new programming
  always_comb begin
    req     = 1'b0;
    req_val = last_req;
    unique case (state)
      CH_UP: begin
        if (ch.pwr_en && settle_done) begin
          req     = 1'b1;
          req_val = ch.vol_prog;
        end
      end
      CH_RUN: begin
        if (!ch.pwr_en) begin
          req     = 1'b1;
          req_val = VOL_MUTE;
        end else if (ch.vol_prog != last_req) begin
          req     = 1'b1;
          req_val = ch.vol_prog;
        end
      end
      CH_OFF, CH_DOWN: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequence
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= CH_OFF;
      settle_cnt <= '0;
    end else begin
      unique case (state)
        CH_OFF: begin
          if (ch.pwr_en) begin
            state      <= CH_UP;
            settle_cnt <= ch.settle_cyc;
          end
        end
        CH_UP: begin
          // Still muted, so the amplifier may drop at once
          if (!ch.pwr_en) begin
            state <= CH_OFF;
          end else if (settle_done) begin
            state <= CH_RUN;
          end else begin
            settle_cnt <= settle_cnt - 1'b1;
          end
        end
        CH_RUN: begin
          if (!ch.pwr_en) begin
            state <= CH_DOWN;
          end
        end
        CH_DOWN: begin
          // Amplifier stays up until the mute has really landed
          if (!pend && applied == VOL_MUTE) begin
            state <= CH_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_req <= VOL_MUTE;
    end else if (req) begin
      last_req <= req_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-crossing update of the applied volume
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      applied  <= VOL_MUTE;
      pend     <= 1'b0;
      pend_val <= VOL_MUTE;
      to_cnt   <= '0;
    end else if (req) begin
      if (!ch.zc_mode) begin
        applied <= req_val;
        pend    <= 1'b0;
      end else begin
        if (pend && ch.keep) begin
          applied <= pend_val;
        end
        pend     <= 1'b1;
        pend_val <= req_val;
        to_cnt   <= ch.timeout_cyc;
      end
    end else if (pend) begin
      if (ch.zc || to_cnt == '0) begin
        applied <= pend_val;
        pend    <= 1'b0;
      end else begin
        to_cnt <= to_cnt - 1'b1;
      end
    end
  end

  assign ch.amp_on  = (state != CH_OFF);
  assign ch.ready   = (state == CH_RUN);
  assign ch.vol_out = applied;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence up_done_s;
    state == CH_UP && ch.pwr_en && settle_done && !ch.zc_mode;
  endsequence

  chk_mute_in_settle: assert property (
    state == CH_UP |-> applied == VOL_MUTE)
    else $error("volume not muted while amplifier settles");
  chk_apply_after_up: assert property (
    up_done_s |=> applied == $past(ch.vol_prog) && ch.ready)
    else $error("programmed volume not applied after power-up");
  chk_mute_before_off: assert property (
    $fell(ch.amp_on) |-> $past(applied) == VOL_MUTE)
    else $error("amplifier powered down while not muted");
  chk_immediate_mode: assert property (
    req && !ch.zc_mode |=> applied == $past(req_val) && !pend)
    else $error("immediate volume change not applied");
  chk_timeout_apply: assert property (
    pend && !req && to_cnt == '0 |=> !pend && applied == $past(pend_val))
    else $error("time-out did not apply pending volume");
  chk_keep_previous: assert property (
    req && ch.zc_mode && pend && ch.keep |=> applied == $past(pend_val))
    else $error("superseded volume not applied at once");
  chk_drop_previous: assert property (
    req && ch.zc_mode && pend && !ch.keep |=> $stable(applied) && pend)
    else $error("superseded volume not dropped");

endmodule : cpms_channel

/* File: logic/cpms_top.sv */
// Channel power and mute sequencer: control registers and eight channels
`timescale 1ns/1ns
module cpms_top #(
  parameter int unsigned TO_UNIT_CYC = cpms_pkg::CYC_PER_MS,
  parameter int unsigned SETTLE_CYC  = cpms_pkg::SETTLE_CYC
) (
  input  wire logic                                       clk_sys,
  input  wire logic                                       rst,
  input  wire logic                                       reg_wr,
  input  wire logic                                       reg_rd,
  input  wire logic [7:0]                                 reg_addr,
  input  wire logic [7:0]                                 reg_wdata,
  output      logic [7:0]                                 reg_rdata,
  input  wire logic [cpms_pkg::NUM_CH-1:0][cpms_pkg::VOL_W-1:0] vol_prog,
  input  wire logic [cpms_pkg::NUM_CH-1:0]                zc_in,
  output      logic [cpms_pkg::NUM_CH-1:0]                amp_on,
  output      logic [cpms_pkg::NUM_CH-1:0][cpms_pkg::VOL_W-1:0] vol_out,
  output      logic [cpms_pkg::NUM_CH-1:0]                chan_ready
);
  import cpms_pkg::*;

  logic [NUM_CH-1:0]         channel_power_control;
  logic                      global_power_down;
  logic [ZC_CFG_W-1:0]       zc_cfg;
  logic [NUM_CH-1:0]         pwr_en;
  logic [NUM_CH-1:0]         zc_s1;
  logic [NUM_CH-1:0]         zc_s2;
  logic [NUM_CH-1:0]         zc_s3;
  logic [NUM_CH-1:0]         zc_level;
  logic [NUM_CH-1:0]         zc_evt;
  logic [NUM_CH-1:0]         next_zc_level;
  logic [CNT_W-1:0]          timeout_cyc;
  logic [ZC_SEL_W-1:0]       zc_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  function automatic logic [CNT_W-1:0] to_cycles(
    input logic [ZC_SEL_W-1:0] sel);
    logic [63:0] prod;
    prod      = 64'(TO_MS[sel]) * 64'(TO_UNIT_CYC);
    to_cycles = prod[CNT_W-1:0];
  endfunction : to_cycles

  // Level a crossing input settles to; a lone disagreeing stage keeps it
  function automatic logic [NUM_CH-1:0] settled_level(
    input logic [NUM_CH-1:0] s2,
    input logic [NUM_CH-1:0] s3,
    input logic [NUM_CH-1:0] lvl);
    settled_level = (s2 & s3) | (lvl & (s2 | s3));
  endfunction : settled_level

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; rst is the reset pin seen active high, so nothing
  // written can survive or slip in while it is held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channel_power_control <= RST_CHAN_PWR;
    end else if (reg_wr && addr_hit(reg_addr, ADDR_CHAN_PWR)) begin
      channel_power_control <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      global_power_down <= RST_GLB_PDN[0];
    end else if (reg_wr && addr_hit(reg_addr, ADDR_GLB_PWR)) begin
      global_power_down <= reg_wdata[GLB_PDN_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zc_cfg <= RST_ZC_CFG;
    end else if (reg_wr && addr_hit(reg_addr, ADDR_ZC_CFG)) begin
      zc_cfg <= reg_wdata[ZC_CFG_W-1:0];
    end
  end

  // Reads answer one cycle later; unmapped offsets read as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (addr_hit(reg_addr, ADDR_CHAN_PWR)) begin
        reg_rdata <= channel_power_control;
      end else if (addr_hit(reg_addr, ADDR_GLB_PWR)) begin
        reg_rdata <= {7'h00, global_power_down};
      end else if (addr_hit(reg_addr, ADDR_ZC_CFG)) begin
        reg_rdata <= {3'h0, zc_cfg};
      end else if (addr_hit(reg_addr, ADDR_STATUS)) begin
        reg_rdata <= chan_ready;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero-crossing comparators arrive asynchronously; a crossing counts
  // once the two later stages agree, which also rejects single glitches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zc_s1    <= '0;
      zc_s2    <= '0;
      zc_s3    <= '0;
      zc_level <= '0;
    end else begin
      zc_s1    <= zc_in;
      zc_s2    <= zc_s1;
      zc_s3    <= zc_s2;
      zc_level <= next_zc_level;
    end
  end

  // Either polarity of a settled change marks a crossing
  assign next_zc_level = settled_level(zc_s2, zc_s3, zc_level);
  assign zc_evt        = zc_level ^ next_zc_level;

  ////////////////////////////////////////////////////////////////////////////
  // Channel power enables and per-channel sequencers
  assign zc_sel      = zc_cfg[ZC_SEL_LSB +: ZC_SEL_W];
  assign timeout_cyc = to_cycles(zc_sel);
  assign pwr_en      = ~channel_power_control
                       & {NUM_CH{~global_power_down}};

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      cpms_chan_if chif ();

      assign chif.pwr_en      = pwr_en[i];
      assign chif.vol_prog    = vol_prog[i];
      assign chif.zc          = zc_evt[i];
      assign chif.zc_mode     = zc_cfg[ZC_MODE_BIT];
      assign chif.keep        = zc_cfg[ZC_KEEP_BIT];
      assign chif.timeout_cyc = timeout_cyc;
      assign chif.settle_cyc  = CNT_W'(SETTLE_CYC);
      assign amp_on[i]        = chif.amp_on;
      assign vol_out[i]       = chif.vol_out;
      assign chan_ready[i]    = chif.ready;

      cpms_channel u_ch (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ch      (chif)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence glb_write_s;
    reg_wr && addr_hit(reg_addr, ADDR_GLB_PWR);
  endsequence

  chk_reset_defaults: assert property (
    $fell(rst) |-> global_power_down && channel_power_control == 8'h00)
    else $error("power bits not at defaults after reset");
  chk_global_write: assert property (
    glb_write_s |=> global_power_down == $past(reg_wdata[GLB_PDN_BIT]))
    else $error("global power-down bit not written from bit 0");
  chk_chan_readback: assert property (
    reg_rd && addr_hit(reg_addr, ADDR_CHAN_PWR)
      |=> reg_rdata == $past(channel_power_control))
    else $error("channel power register read back wrong");
  chk_global_holds_off: assert property (
    global_power_down && amp_on == '0 |=> amp_on == '0)
    else $error("amplifier powered while global power-down set");
  chk_up_needs_both: assert property (
    ((amp_on & ~$past(amp_on)) & ~$past(pwr_en)) == '0)
    else $error("channel powered up without both bits clear");
  chk_global_stops: assert property (
    $rose(global_power_down) |=> chan_ready == '0)
    else $error("channel kept running after global power-down");
  chk_zc_agree: assert property (
    zc_evt != '0 |-> (zc_evt & (zc_s2 ^ zc_s3)) == '0)
    else $error("crossing taken before sync stages agreed");
  chk_timeout_sel: assert property (
    zc_sel == 3'h7 |-> timeout_cyc == CNT_W'(50 * TO_UNIT_CYC))
    else $error("longest time-out setting wrong");
  chk_timeout_short: assert property (
    zc_sel == 3'h0 |-> timeout_cyc == CNT_W'(5 * TO_UNIT_CYC))
    else $error("shortest time-out setting wrong");

  // Register writes and read-back
  sequence chan_write_s;
    reg_wr && addr_hit(reg_addr, ADDR_CHAN_PWR);
  endsequence

  sequence cfg_write_s;
    reg_wr && addr_hit(reg_addr, ADDR_ZC_CFG);
  endsequence

  chk_chan_write: assert property (
    chan_write_s |=> channel_power_control == $past(reg_wdata))
    else $error("channel power bits not written");
  chk_cfg_write: assert property (
    cfg_write_s |=> zc_cfg == $past(reg_wdata[ZC_CFG_W-1:0]))
    else $error("zero-crossing settings not written");
  chk_glb_readback: assert property (
    reg_rd && addr_hit(reg_addr, ADDR_GLB_PWR)
      |=> reg_rdata == {7'h00, $past(global_power_down)})
    else $error("global power-down bit read back wrong");
  chk_cfg_readback: assert property (
    reg_rd && addr_hit(reg_addr, ADDR_ZC_CFG)
      |=> reg_rdata == {3'h0, $past(zc_cfg)})
    else $error("zero-crossing settings read back wrong");
  chk_status_read: assert property (
    reg_rd && addr_hit(reg_addr, ADDR_STATUS)
      |=> reg_rdata == $past(chan_ready))
    else $error("channel ready status read back wrong");
  chk_unmapped_zero: assert property (
    reg_rd && !addr_hit(reg_addr, ADDR_CHAN_PWR)
      && !addr_hit(reg_addr, ADDR_GLB_PWR)
      && !addr_hit(reg_addr, ADDR_ZC_CFG)
      && !addr_hit(reg_addr, ADDR_STATUS) |=> reg_rdata == 8'h00)
    else $error("unmapped offset did not read as zero");

  // State right after reset is released
  chk_reset_outputs: assert property (
    $fell(rst) |-> amp_on == '0 && chan_ready == '0 && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  chk_reset_cfg: assert property (
    $fell(rst) |-> zc_cfg == RST_ZC_CFG)
    else $error("zero-crossing settings not at default after reset");

  // Enable decode from the two power-down bits
  chk_global_zero_en: assert property (
    global_power_down |-> pwr_en == '0)
    else $error("channel enabled while global power-down set");
  chk_en_decode: assert property (
    !global_power_down |-> pwr_en == ~channel_power_control)
    else $error("channel enable does not follow its own bit");
  chk_ready_needs_en: assert property (
    (chan_ready & ~$past(pwr_en)) == '0)
    else $error("channel still running after power-down request");

  // Crossing detector follows the settled level
  chk_zc_follow: assert property (
    zc_s2 == zc_s3 |=> zc_level == $past(zc_s2))
    else $error("crossing level did not follow agreeing stages");

  // Per-channel power and mute relations
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
      chk_off_muted: assert property (
        !amp_on[i] |-> vol_out[i] == VOL_MUTE)
        else $error("unpowered channel not muted");
      chk_ready_powered: assert property (
        chan_ready[i] |-> amp_on[i])
        else $error("channel ready without amplifier power");
      chk_up_from_en: assert property (
        $rose(amp_on[i]) |-> $past(pwr_en[i]))
        else $error("amplifier powered without enable");
    end
  endgenerate

endmodule : cpms_top

/* File: bench/cpms_host.sv */
// Host controller model driving the sequencer register port
`timescale 1ns/1ns
module cpms_host (
  input  wire logic       clk_sys,
  output      logic       reg_wr,
  output      logic       reg_rd,
  output      logic [7:0] reg_addr,
  output      logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle strobe; stale data inverted so nothing relies on it
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    data = reg_rdata;
  endtask : read_reg
endmodule : cpms_host

/* File: bench/testbench.sv */
// Self-checking bench for the channel power and mute sequencer
`timescale 1ns/1ns
module testbench;
  import cpms_pkg::*;
  localparam int unsigned TO_UNIT = 4;
  localparam int unsigned SETTLE  = 5;
  localparam int          LIMIT   = 20000;

  logic                         clk_sys;
  logic                         rst;
  logic                         reg_wr;
  logic                         reg_rd;
  logic [7:0]                   reg_addr;
  logic [7:0]                   reg_wdata;
  logic [7:0]                   reg_rdata;
  logic [NUM_CH-1:0][VOL_W-1:0] vol_prog;
  logic [NUM_CH-1:0]            zc_in;
  logic [NUM_CH-1:0]            amp_on;
  logic [NUM_CH-1:0][VOL_W-1:0] vol_out;
  logic [NUM_CH-1:0]            chan_ready;
  logic [7:0]                   rd;
  int                           failures = 0;
  int                           checks = 0;
  int                           cycles = 0;

  cpms_top #(.TO_UNIT_CYC(TO_UNIT), .SETTLE_CYC(SETTLE)) i_cpms_top (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_rdata  (reg_rdata),
    .vol_prog   (vol_prog),
    .zc_in      (zc_in),
    .amp_on     (amp_on),
    .vol_out    (vol_out),
    .chan_ready (chan_ready)
  );

  cpms_host i_cpms_host (
    .clk_sys   (clk_sys),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Sample 1 ns after the edge so that edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cpms_host.write_reg(a, d);
  endtask : wr

  task automatic zc_edge(input int ch);
    @(posedge clk_sys);
    zc_in[ch] <= ~zc_in[ch];
  endtask : zc_edge

  // Last volume seen while the amplifier was still powered must be mute
  task automatic watch_down(input int ch, input int n);
    logic [7:0] last;
    last = 8'hFF;
    repeat (n) begin
      @(negedge clk_sys);
      if (amp_on[ch] === 1'b1) last = vol_out[ch];
    end
    check("vol_before_off", last, VOL_MUTE);
    check("amp_after_down", amp_on[ch], 1'b0);
  endtask : watch_down

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    i_cpms_host.read_reg(ADDR_CHAN_PWR, rd);
    check("chan_pwr", rd, RST_CHAN_PWR);
    i_cpms_host.read_reg(ADDR_GLB_PWR, rd);
    check("glb_pwr", rd, {7'h00, RST_GLB_PDN});
    i_cpms_host.read_reg(ADDR_ZC_CFG, rd);
    check("zc_cfg", rd, RST_ZC_CFG);
    tick(20);
    check("amp_idle", amp_on, 8'h00);
    check("vol_idle", vol_out, 64'h0);
    $display("Test defaults done");
  endtask : t_defaults

  task automatic t_power_up;
    logic [NUM_CH-1:0][VOL_W-1:0] exp;
    @(posedge clk_sys);
    for (int c = 0; c < NUM_CH; c++) vol_prog[c] <= 8'h10 + 8'(c);
    wr(ADDR_ZC_CFG, 8'h00);
    wr(ADDR_CHAN_PWR, 8'h80);
    wr(ADDR_GLB_PWR, 8'h00);
    tick(3);
    check("amp_up", amp_on, 8'h7F);
    check("mute_settle", vol_out, 64'h0);
    check("ready_early", chan_ready, 8'h00);
    tick(SETTLE + 6);
    exp = vol_prog;
    exp[7] = VOL_MUTE;
    check("ready_up", chan_ready, 8'h7F);
    check("vol_applied", vol_out, exp);
    i_cpms_host.read_reg(ADDR_CHAN_PWR, rd);
    check("chan_rd", rd, 8'h80);
    i_cpms_host.read_reg(ADDR_STATUS, rd);
    check("status_rd", rd, 8'h7F);
    i_cpms_host.read_reg(8'h20, rd);
    check("unmapped_rd", rd, 8'h00);
    wr(ADDR_CHAN_PWR, 8'h81);
    watch_down(0, 10);
    check("ready_down", chan_ready, 8'h7E);
    $display("Test power up done");
  endtask : t_power_up

  task automatic t_timeouts;
    logic [7:0] old;
    old = 8'h11;
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_ZC_CFG, 8'(s * 2 + 1));
      @(posedge clk_sys);
      vol_prog[1] <= 8'h40 + 8'(s);
      tick(int'(TO_MS[s] * TO_UNIT) - 2);
      check("zc_hold", vol_out[1], old);
      tick(6);
      old = 8'h40 + 8'(s);
      check("zc_timeout", vol_out[1], old);
    end
    $display("Test time-outs done");
  endtask : t_timeouts

  task automatic t_zero_cross;
    wr(ADDR_ZC_CFG, 8'h0F);
    @(posedge clk_sys);
    vol_prog[2] <= 8'h55;
    tick(5);
    check("zc_wait", vol_out[2], 8'h12);
    zc_edge(2);
    tick(6);
    check("zc_apply", vol_out[2], 8'h55);
    // Keep, then drop, a superseded change
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_ZC_CFG, k ? 8'h0F : 8'h1F);
      @(posedge clk_sys);
      vol_prog[3] <= 8'hA0 + 8'(k * 2);
      @(posedge clk_sys);
      vol_prog[3] <= 8'hA1 + 8'(k * 2);
      tick(3);
      check("superseded", vol_out[3], k ? 8'hA1 : 8'hA0);
      zc_edge(3);
      tick(6);
      check("newest", vol_out[3], 8'hA1 + 8'(k * 2));
    end
    $display("Test zero-crossing done");
  endtask : t_zero_cross

  task automatic t_global_down;
    wr(ADDR_ZC_CFG, 8'h01);
    wr(ADDR_GLB_PWR, 8'h01);
    tick(5);
    check("amp_wait_zc", amp_on, 8'h7E);
    check("vol_wait_zc", vol_out[2], 8'h55);
    watch_down(2, 40);
    check("all_off", amp_on, 8'h00);
    check("all_mute", vol_out, 64'h0);
    $display("Test global down done");
  endtask : t_global_down

  task automatic t_mid_reset;
    wr(ADDR_CHAN_PWR, 8'h55);
    wr(ADDR_ZC_CFG, 8'h00);
    @(posedge clk_sys);
    rst <= 1'b1;
    wr(ADDR_CHAN_PWR, 8'h0F);
    tick(2);
    check("rst_amp", amp_on, 8'h00);
    @(posedge clk_sys);
    rst <= 1'b0;
    i_cpms_host.read_reg(ADDR_CHAN_PWR, rd);
    check("rst_chan", rd, RST_CHAN_PWR);
    i_cpms_host.read_reg(ADDR_ZC_CFG, rd);
    check("rst_zc", rd, RST_ZC_CFG);
    $display("Test mid-run reset done");
  endtask : t_mid_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst      = 1'b1;
    vol_prog = '0;
    zc_in    = '0;
    repeat (6) @(posedge clk_sys);
    // Accesses while reset is held must be ignored
    wr(ADDR_GLB_PWR, 8'h00);
    wr(ADDR_CHAN_PWR, 8'hFF);
    @(posedge clk_sys);
    rst <= 1'b0;
    t_defaults();
    t_power_up();
    t_timeouts();
    t_zero_cross();
    t_global_down();
    t_mid_reset();
    close_out();
  end
endmodule : testbench
